/* File: hw/ira_engine.sv */
// What this block does
// - squelch bit set enables converter voice-band squelch, clear disables
// - hysteresis bit set applies loop-closure hysteresis, clear none
// - with hysteresis, upper threshold from register 15, lower from 66
// - data write then address write forms a write request
// - serviced write stores data at the requested indirect address
// - address write without prior data write is a read request
// - serviced read copies addressed indirect value into data register
// - transfers serviced only on 16 kHz update ticks, one per tick
// - pending status bit is one from request until serviced
// - completion flag in register 20 raised when a transfer finishes
// - oscillator register values are two's-complement numbers
// - tone generator 1 uses indirect registers 0, 1 and 2
// - tone generator 2 uses indirect registers 3, 4 and 5
// - ringing generator uses indirect registers 7, 8 and 9
// - ringing dc offset is a 6-bit field of register 6
// - gain block at 13-27, 64 and 66, fsk registers 69-74
// - fsk enable with release bit: tone 1 at 24 kHz, fsk registers
//
// Purpose: direct-register side of the indirect register bank
// Assumes: host port is synchronous to i_clk, one access per cycle
// Notes: read data appears the cycle after i_dreg_rd
//    indirect bank has no reset; coefficient taps show X until written
`timescale 1ns/1ps
module ira_engine (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_dreg_wr,
   input wire logic i_dreg_rd,
   input wire logic [ira_pkg::DREG_AW-1:0] i_dreg_addr,
   input wire logic [ira_pkg::DREG_DW-1:0] i_dreg_wdata,
   output logic [ira_pkg::DREG_DW-1:0] o_dreg_rdata,
   output logic o_indirect_pending_flag,
   output logic o_indirect_done_irq,
   output logic o_converter_squelch_en,
   output logic o_loop_hysteresis_en,
   output logic signed [ira_pkg::IND_DW-1:0] o_loop_threshold_upper,
   output logic signed [ira_pkg::IND_DW-1:0] o_loop_threshold_lower,
   output logic o_tone1_tick,
   output logic o_tone1_fsk_sel,
   output logic signed [ira_pkg::IND_DW-1:0] o_tone1_frequency_coeff,
   output logic signed [ira_pkg::IND_DW-1:0] o_tone1_amplitude,
   output logic signed [ira_pkg::IND_DW-1:0] o_tone1_initial_phase,
   output logic signed [ira_pkg::IND_DW-1:0] o_tone2_frequency_coeff,
   output logic signed [ira_pkg::IND_DW-1:0] o_tone2_amplitude,
   output logic signed [ira_pkg::IND_DW-1:0] o_tone2_initial_phase,
   output logic [ira_pkg::RING_OFFSET_W-1:0] o_ring_dc_offset,
   output logic signed [ira_pkg::IND_DW-1:0] o_ring_frequency_coeff,
   output logic signed [ira_pkg::IND_DW-1:0] o_ring_amplitude,
   output logic signed [ira_pkg::IND_DW-1:0] o_ring_initial_phase,
   output logic signed [ira_pkg::IND_DW-1:0] o_minimum_voltage_setting
);
   import ira_pkg::*;

   // ==========================================================
   // reset release
   // async assert, release through two flops
   logic rst_meta;
   logic rst_n;

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // ==========================================================
   // rate enables
   logic update_tick;
   logic tone_slow_tick;
   logic tone_fast_tick;

   ira_rate_div #(.DIV(UPDATE_DIV)) u_update_div (
      .i_clk(i_clk),
      .i_rst_n(rst_n),
      .o_tick(update_tick)
   );

   ira_rate_div #(.DIV(TONE_SLOW_DIV)) u_slow_div (
      .i_clk(i_clk),
      .i_rst_n(rst_n),
      .o_tick(tone_slow_tick)
   );

   ira_rate_div #(.DIV(TONE_FAST_DIV)) u_fast_div (
      .i_clk(i_clk),
      .i_rst_n(rst_n),
      .o_tick(tone_fast_tick)
   );

   // ==========================================================
   // direct write decode
   function automatic logic dwr(input logic [DREG_AW-1:0] a);
      dwr = i_dreg_wr && (i_dreg_addr == a);
   endfunction : dwr

   logic wr_data_lo;
   logic wr_data_hi;
   logic wr_addr;
   assign wr_data_lo = dwr(DREG_IND_DATA_LO);
   assign wr_data_hi = dwr(DREG_IND_DATA_HI);
   assign wr_addr = dwr(DREG_IND_ADDR);

   // ==========================================================
   // control registers
   logic [DREG_DW-1:0] enhance;
   logic [DREG_DW-1:0] line_ctrl;

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         enhance <= RESET_VALUE;
      end else if (dwr(DREG_ENHANCE)) begin
         enhance <= i_dreg_wdata & ENHANCE_MASK;
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         line_ctrl <= RESET_VALUE;
      end else if (dwr(DREG_LINE_CTRL)) begin
         line_ctrl <= i_dreg_wdata;
      end
   end

   // ==========================================================
   // request tracking
   logic data_written;
   logic pending;
   logic pending_write;
   logic [IND_AW-1:0] ind_addr;
   logic [IND_DW-1:0] ind_data;
   logic service;
   logic [IND_DW-1:0] mem [IND_DEPTH];

   // one transfer per tick, only when something waits
   assign service = update_tick && pending;

   // a data byte write arms the next address write as a write
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         data_written <= 1'b0;
      end else if (wr_addr) begin
         data_written <= 1'b0;
      end else if (wr_data_lo || wr_data_hi) begin
         data_written <= 1'b1;
      end
   end

   // an address write issues the request
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         pending <= 1'b0;
         pending_write <= 1'b0;
         ind_addr <= '0;
      end else if (wr_addr) begin
         pending <= 1'b1;
         pending_write <= data_written;
         ind_addr <= i_dreg_wdata[IND_AW-1:0];
      end else if (service) begin
         pending <= 1'b0;
      end
   end

   // readback copy wins over a host byte write in the same cycle
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         ind_data <= '0;
      end else if (service && !pending_write) begin
         ind_data <= mem[ind_addr];
      end else begin
         if (wr_data_lo) begin
            ind_data[7:0] <= i_dreg_wdata;
         end
         if (wr_data_hi) begin
            ind_data[15:8] <= i_dreg_wdata;
         end
      end
   end

   // indirect bank: no reset, contents undefined until programmed
   always_ff @(posedge i_clk) begin
      if (service && pending_write) begin
         mem[ind_addr] <= ind_data;
      end
   end

   // ==========================================================
   // completion flag, write one to clear; set wins over clear
   logic done_flag;

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         done_flag <= 1'b0;
      end else if (service) begin
         done_flag <= 1'b1;
      end else if (dwr(DREG_IRQ_STATUS) && i_dreg_wdata[DONE_IRQ_BIT]) begin
         done_flag <= 1'b0;
      end
   end

   // ==========================================================
   // direct read mux
   logic [DREG_DW-1:0] next_rdata;

   always_comb begin
      next_rdata = '0;
      case (i_dreg_addr)
         DREG_IRQ_STATUS: next_rdata[DONE_IRQ_BIT] = done_flag;
         DREG_IND_DATA_LO: next_rdata = ind_data[7:0];
         DREG_IND_DATA_HI: next_rdata = ind_data[15:8];
         DREG_IND_ADDR: next_rdata = {1'b0, ind_addr};
         DREG_IND_STATUS: next_rdata[PENDING_BIT] = pending;
         DREG_LINE_CTRL: next_rdata = line_ctrl;
         DREG_ENHANCE: next_rdata = enhance;
         default: next_rdata = '0;
      endcase
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_dreg_rdata <= '0;
      end else if (i_dreg_rd) begin
         o_dreg_rdata <= next_rdata;
      end
   end

   // ==========================================================
   // status and enhancement outputs
   logic fsk_mode;
   assign fsk_mode = enhance[FSK_EN_BIT] && line_ctrl[RELEASE_BIT];

   // one cycle behind the status register bit
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_indirect_pending_flag <= 1'b0;
         o_indirect_done_irq <= 1'b0;
      end else begin
         o_indirect_pending_flag <= pending;
         o_indirect_done_irq <= done_flag;
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_converter_squelch_en <= 1'b0;
         o_loop_hysteresis_en <= 1'b0;
         o_tone1_fsk_sel <= 1'b0;
      end else begin
         o_converter_squelch_en <= enhance[SQUELCH_EN_BIT];
         o_loop_hysteresis_en <= enhance[HYST_EN_BIT];
         o_tone1_fsk_sel <= fsk_mode;
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_tone1_tick <= 1'b0;
      end else begin
         // fast rate only while releasing; 24 kHz rounds to 833 cycles
         o_tone1_tick <= fsk_mode ? tone_fast_tick : tone_slow_tick;
      end
   end

   // ==========================================================
   // coefficient taps, two's complement except the unsigned 6-bit ring dc offset
   // registered copies of the bank; no reset since the bank has none
   always_ff @(posedge i_clk) begin
      o_tone1_frequency_coeff <= fsk_mode ? mem[IR_FSK_FREQ0]
         : mem[IR_TONE1_FREQ];
      o_tone1_amplitude <= fsk_mode ? mem[IR_FSK_AMP0]
         : mem[IR_TONE1_AMP];
      o_tone1_initial_phase <= mem[IR_TONE1_PHASE];
   end

   always_ff @(posedge i_clk) begin
      o_tone2_frequency_coeff <= mem[IR_TONE2_FREQ];
      o_tone2_amplitude <= mem[IR_TONE2_AMP];
      o_tone2_initial_phase <= mem[IR_TONE2_PHASE];
   end

   // offset field only; the upper bits stay readable in the bank
   always_ff @(posedge i_clk) begin
      o_ring_dc_offset <=
         mem[IR_RING_OFFSET][RING_OFFSET_LSB +: RING_OFFSET_W];
      o_ring_frequency_coeff <= mem[IR_RING_FREQ];
      o_ring_amplitude <= mem[IR_RING_AMP];
      o_ring_initial_phase <= mem[IR_RING_PHASE];
   end

   // line-control thresholds and voltage floor
   always_ff @(posedge i_clk) begin
      o_minimum_voltage_setting <= mem[IR_MIN_VOLTAGE];
      o_loop_threshold_upper <= mem[IR_LOOP_THR_UPPER];
      // without hysteresis both edges collapse onto the upper threshold
      o_loop_threshold_lower <= enhance[HYST_EN_BIT] ?
         mem[IR_LOOP_THR_LOWER] : mem[IR_LOOP_THR_UPPER];
   end
endmodule : ira_engine

/* File: hw/ira_pkg.sv */
// Purpose: constants shared by the indirect register access engine
// Assumes: 20 MHz system clock, 8-bit direct registers, 16-bit indirect
// Notes: direct and indirect addresses are register numbers, not bytes
package ira_pkg;
   // ==========================================================
   // widths
   localparam int DREG_AW = 8;
   localparam int DREG_DW = 8;
   localparam int IND_AW = 7;
   localparam int IND_DW = 16;
   localparam int IND_DEPTH = 128;

   // ==========================================================
   // direct register numbers
   localparam logic [7:0] DREG_IRQ_STATUS = 8'h14;   // register 20
   localparam logic [7:0] DREG_IND_DATA_LO = 8'h1C;
   localparam logic [7:0] DREG_IND_DATA_HI = 8'h1D;
   localparam logic [7:0] DREG_IND_ADDR = 8'h1E;
   localparam logic [7:0] DREG_IND_STATUS = 8'h1F;   // register 31
   localparam logic [7:0] DREG_LINE_CTRL = 8'h20;    // register 32
   localparam logic [7:0] DREG_ENHANCE = 8'h6C;      // register 108

   // ==========================================================
   // field positions
   localparam int DONE_IRQ_BIT = 0;
   localparam int PENDING_BIT = 0;
   localparam int RELEASE_BIT = 6;
   localparam int HYST_EN_BIT = 0;
   localparam int SQUELCH_EN_BIT = 1;
   localparam int FSK_EN_BIT = 6;
   localparam logic [7:0] ENHANCE_MASK = 8'hE7;  // bits 4:3 reserved
   localparam logic [7:0] RESET_VALUE = 8'h00;
   localparam int RING_OFFSET_LSB = 0;
   localparam int RING_OFFSET_W = 6;

   // ==========================================================
   // indirect register numbers
   localparam logic [6:0] IR_TONE1_FREQ = 7'h00;
   localparam logic [6:0] IR_TONE1_AMP = 7'h01;
   localparam logic [6:0] IR_TONE1_PHASE = 7'h02;
   localparam logic [6:0] IR_TONE2_FREQ = 7'h03;
   localparam logic [6:0] IR_TONE2_AMP = 7'h04;
   localparam logic [6:0] IR_TONE2_PHASE = 7'h05;
   localparam logic [6:0] IR_RING_OFFSET = 7'h06;
   localparam logic [6:0] IR_RING_FREQ = 7'h07;
   localparam logic [6:0] IR_RING_AMP = 7'h08;
   localparam logic [6:0] IR_RING_PHASE = 7'h09;
   localparam logic [6:0] IR_GAIN_FIRST = 7'h0D;      // 13..27
   localparam logic [6:0] IR_LOOP_THR_UPPER = 7'h0F;  // legacy 28
   localparam logic [6:0] IR_GAIN_LAST = 7'h1B;
   localparam logic [6:0] IR_MIN_VOLTAGE = 7'h40;     // 64
   localparam logic [6:0] IR_LOOP_THR_LOWER = 7'h42;  // 66, legacy 43
   localparam logic [6:0] IR_FSK_AMP0 = 7'h45;        // 69..74
   localparam logic [6:0] IR_FSK_FREQ0 = 7'h46;
   localparam logic [6:0] IR_FSK_LAST = 7'h4A;

   // ==========================================================
   // timing
   localparam int CLK_HZ = 20_000_000;
   localparam int UPDATE_HZ = 16_000;
   localparam int TONE_SLOW_HZ = 8_000;
   localparam int TONE_FAST_HZ = 24_000;
   localparam int UPDATE_DIV = CLK_HZ / UPDATE_HZ;       // 1250
   localparam int TONE_SLOW_DIV = CLK_HZ / TONE_SLOW_HZ; // 2500
   localparam int TONE_FAST_DIV = CLK_HZ / TONE_FAST_HZ; // 833
endpackage : ira_pkg

/* File: hw/ira_rate_div.sv */
// Purpose: free-running divider giving a one-cycle enable pulse
// Assumes: synchronous reset copy, DIV of at least 2
// Notes: pulse lands one cycle after the last count of each period
`timescale 1ns/1ps
module ira_rate_div #(
   parameter int DIV = 1250
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   output logic o_tick
);
   localparam int CW = $clog2(DIV);
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);
   logic [CW-1:0] count;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         count <= '0;
         o_tick <= 1'b0;
      end else begin
         o_tick <= (count == LAST);
         if (count == LAST) begin
            count <= '0;
         end else begin
            count <= count + 1'b1;
         end
      end
   end
endmodule : ira_rate_div

/* File: sim/ira_checker.sv */
// Purpose: port assertions for the indirect access engine
// Assumes: one clock domain, active-low reset
// Notes: enh shadows the last enhancement write
`timescale 1ns/1ps
module ira_checker (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_dreg_wr,
   input wire logic i_dreg_rd,
   input wire logic [ira_pkg::DREG_AW-1:0] i_dreg_addr,
   input wire logic [ira_pkg::DREG_DW-1:0] i_dreg_wdata,
   input wire logic [ira_pkg::DREG_DW-1:0] o_dreg_rdata,
   input wire logic o_indirect_pending_flag,
   input wire logic o_indirect_done_irq,
   input wire logic o_converter_squelch_en,
   input wire logic o_loop_hysteresis_en,
   input wire logic o_tone1_tick
);
   import ira_pkg::*;
   logic wr_enh, wr_addr, clr_irq;
   logic [7:0] enh;
   assign wr_enh = i_dreg_wr && i_dreg_addr == DREG_ENHANCE;
   assign wr_addr = i_dreg_wr && i_dreg_addr == DREG_IND_ADDR;
   // clear only when idle, a service in flight would win
   assign clr_irq = i_dreg_wr && i_dreg_addr == DREG_IRQ_STATUS
      && i_dreg_wdata[0] && !o_indirect_pending_flag;
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) enh <= 8'h00;
      else if (wr_enh) enh <= i_dreg_wdata;
   end
   // a tick every UPDATE_DIV cycles bounds how long a request may wait
   int wait_cnt;
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) wait_cnt <= 0;
      else if (o_indirect_pending_flag) wait_cnt <= wait_cnt + 1;
      else wait_cnt <= 0;
   end
   // ========
   // assertions
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   a_squelch_bit:
      assert property (!$past(wr_enh) && !$past(wr_enh, 2)
      |-> o_converter_squelch_en == enh[1]) else $error("squelch bit");
   a_hyst_bit:
      assert property (!$past(wr_enh) && !$past(wr_enh, 2)
      |-> o_loop_hysteresis_en == enh[0]) else $error("hysteresis bit");
   a_service_bound:
      assert property (wait_cnt <= UPDATE_DIV)
      else $error("transfer not serviced");
   a_pending_cause:
      assert property ($rose(o_indirect_pending_flag)
      |-> $past(wr_addr, 2) || $past(wr_addr, 3)) else $error("stray pending");
   a_done_cause:
      assert property ($rose(o_indirect_done_irq)
      |-> $fell(o_indirect_pending_flag)) else $error("stray done");
   a_done_clear:
      assert property (clr_irq |-> ##2 !o_indirect_done_irq)
      else $error("done not cleared");
   a_rdata_hold:
      assert property (!$past(i_dreg_rd) && !$past(i_dreg_rd, 2)
      |-> $stable(o_dreg_rdata)) else $error("read data moved");
   a_tick_pulse:
      assert property (o_tone1_tick |=> !o_tone1_tick)
      else $error("long tick");
   c_served: cover property ($fell(o_indirect_pending_flag));
   c_done: cover property ($rose(o_indirect_done_irq));
   c_clear: cover property (clr_irq);
endmodule : ira_checker

bind ira_engine ira_checker u_ira_checker (.i_clk(i_clk),
   .i_resetn(i_resetn), .i_dreg_wr(i_dreg_wr), .i_dreg_rd(i_dreg_rd),
   .i_dreg_addr(i_dreg_addr), .i_dreg_wdata(i_dreg_wdata),
   .o_dreg_rdata(o_dreg_rdata), .o_tone1_tick(o_tone1_tick),
   .o_indirect_pending_flag(o_indirect_pending_flag),
   .o_indirect_done_irq(o_indirect_done_irq),
   .o_converter_squelch_en(o_converter_squelch_en),
   .o_loop_hysteresis_en(o_loop_hysteresis_en));

/* File: sim/ira_host.sv */
// Purpose: host controller model on the direct register port
// Assumes: strobes driven on falling edges, one access at a time
// Notes: released lines show inverted values so stale data never passes
`timescale 1ns/1ps
module ira_host (
   input wire logic i_clk,
   input wire logic i_pending,
   input wire logic [ira_pkg::DREG_DW-1:0] i_rdata,
   output logic o_wr,
   output logic o_rd,
   output logic [ira_pkg::DREG_AW-1:0] o_addr,
   output logic [ira_pkg::DREG_DW-1:0] o_wdata
);
   import ira_pkg::*;
   int stalls = 0;
   initial begin
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = 8'hFF;
      o_wdata = 8'hFF;
   end
   // ========
   // direct accesses
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clk);
      o_wr = 1'b1;
      o_addr = a;
      o_wdata = d;
      @(negedge i_clk);
      o_wr = 1'b0;
      o_addr = ~a;
      o_wdata = ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge i_clk);
      o_rd = 1'b1;
      o_addr = a;
      @(negedge i_clk);
      o_rd = 1'b0;
      o_addr = ~a;
      @(negedge i_clk);
      d = i_rdata;
   endtask : rd
   // ========
   // indirect transfers
   task automatic idle;
      int n;
      n = 0;
      repeat (3) @(negedge i_clk);
      while (i_pending !== 1'b0 && n < 1400) begin
         @(negedge i_clk);
         n++;
      end
      if (n >= 1400) begin
         stalls++;
      end
   endtask : idle
   task automatic iwr(input logic [6:0] a, input logic [15:0] d);
      wr(DREG_IND_DATA_LO, d[7:0]);
      wr(DREG_IND_DATA_HI, d[15:8]);
      wr(DREG_IND_ADDR, {1'b0, a});
      idle();
   endtask : iwr
   task automatic ird(input logic [6:0] a, output logic [15:0] d);
      wr(DREG_IND_ADDR, {1'b0, a});
      idle();
      rd(DREG_IND_DATA_LO, d[7:0]);
      rd(DREG_IND_DATA_HI, d[15:8]);
   endtask : ird
endmodule : ira_host

/* File: sim/tb_top.sv */
// Purpose: self-checking bench for the indirect access engine
// Assumes: 20 MHz clock, host model drives on falling edges
// Notes: tone tick periods are measured at full length
`timescale 1ns/1ps
module tb_top;
   import ira_pkg::*;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic wr, rd, pend, done, sq, hy, tick, fsel;
   logic [7:0] addr, wdata, rdata, d8;
   logic signed [15:0] up, lo, minv;
   logic [15:0] d16;
   wire [9:0][15:0] ov;
   int err_count = 0;
   int total_checks = 0;
   int per;
   logic [15:0] v [10] = '{16'h8000, 16'h7FFF, 16'h1234, 16'hFEDC, 16'h0001,
      16'hA5A5, 16'h002A, 16'h5A5A, 16'hC003, 16'h0FF0};
   assign ov[6][15:6] = 10'h000;
   always #25 clk = ~clk;
   ira_engine u_ira_engine (.i_clk(clk), .i_resetn(resetn), .i_dreg_wr(wr),
      .i_dreg_rd(rd), .i_dreg_addr(addr), .i_dreg_wdata(wdata),
      .o_dreg_rdata(rdata), .o_indirect_pending_flag(pend),
      .o_indirect_done_irq(done), .o_converter_squelch_en(sq),
      .o_loop_hysteresis_en(hy), .o_loop_threshold_upper(up),
      .o_loop_threshold_lower(lo), .o_tone1_tick(tick),
      .o_tone1_fsk_sel(fsel), .o_tone1_frequency_coeff(ov[0]),
      .o_tone1_amplitude(ov[1]), .o_tone1_initial_phase(ov[2]),
      .o_tone2_frequency_coeff(ov[3]), .o_tone2_amplitude(ov[4]),
      .o_tone2_initial_phase(ov[5]), .o_ring_dc_offset(ov[6][5:0]),
      .o_ring_frequency_coeff(ov[7]), .o_ring_amplitude(ov[8]),
      .o_ring_initial_phase(ov[9]), .o_minimum_voltage_setting(minv));
   ira_host u_ira_host (.i_clk(clk), .i_pending(pend), .i_rdata(rdata),
      .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
   // ========
   // helpers
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask : check
   task automatic period;
      per = 0;
      while (tick !== 1'b1 && per < 3000) begin
         @(negedge clk);
         per++;
      end
      per = 0;
      do begin
         @(negedge clk);
         per++;
      end while (tick !== 1'b1 && per < 3000);
   endtask : period
   // ========
   // scenarios
   task automatic t_enh;
      check({pend, done, sq, hy, fsel}, 16'h0000);
      u_ira_host.rd(DREG_ENHANCE, d8);
      check(d8, RESET_VALUE);
      u_ira_host.rd(8'h05, d8);
      check(d8, 8'h00);
      u_ira_host.wr(DREG_ENHANCE, 8'hFF);
      u_ira_host.rd(DREG_ENHANCE, d8);
      check(d8, ENHANCE_MASK);
      check({sq, hy}, 2'b11);
      u_ira_host.iwr(IR_LOOP_THR_UPPER, 16'h0300);
      u_ira_host.iwr(IR_LOOP_THR_LOWER, 16'h0100);
      check(up, 16'h0300);
      check(lo, 16'h0100);
      u_ira_host.wr(DREG_ENHANCE, 8'h00);
      u_ira_host.rd(DREG_ENHANCE, d8);
      check({sq, hy}, 2'b00);
      check(lo, 16'h0300);
      u_ira_host.iwr(IR_MIN_VOLTAGE, 16'h1357);
      check(minv, 16'h1357);
   endtask : t_enh
   task automatic t_osc;
      for (int k = 0; k < 10; k++) begin
         u_ira_host.iwr(7'(k), v[k]);
      end
      for (int k = 0; k < 10; k++) begin
         check(ov[k], v[k]);
      end
      for (int k = 9; k >= 0; k--) begin
         u_ira_host.ird(7'(k), d16);
         check(d16, v[k]);
      end
   endtask : t_osc
   task automatic t_pend;
      u_ira_host.wr(DREG_IRQ_STATUS, 8'h01);
      repeat (2) @(negedge clk);
      check(done, 1'b0);
      u_ira_host.wr(DREG_IND_ADDR, {1'b0, IR_TONE2_PHASE});
      u_ira_host.rd(DREG_IND_STATUS, d8);
      check(d8[0], 1'b1);
      u_ira_host.idle();
      u_ira_host.rd(DREG_IRQ_STATUS, d8);
      check({done, d8[0]}, 2'b11);
      u_ira_host.rd(DREG_IND_DATA_LO, d8);
      check(d8, v[5][7:0]);
   endtask : t_pend
   // second period only: the first may straddle the mode change
   task automatic t_fsk;
      u_ira_host.iwr(IR_FSK_AMP0, 16'h2222);
      u_ira_host.iwr(IR_FSK_FREQ0, 16'h3333);
      u_ira_host.wr(DREG_LINE_CTRL, 8'h40);
      u_ira_host.wr(DREG_ENHANCE, 8'h40);
      period();
      period();
      check(16'(per), 16'(TONE_FAST_DIV));
      check(fsel, 1'b1);
      check(ov[0], 16'h3333);
      check(ov[1], 16'h2222);
      u_ira_host.wr(DREG_LINE_CTRL, 8'h00);
      period();
      period();
      check(16'(per), 16'(TONE_SLOW_DIV));
      check(fsel, 1'b0);
      check(ov[0], v[0]);
   endtask : t_fsk
   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : final_report
   initial begin
      repeat (20) @(negedge clk);
      resetn = 1'b1;
      repeat (3) @(negedge clk);
      t_enh();
      t_osc();
      t_pend();
      t_fsk();
      check(16'(u_ira_host.stalls), 16'h0000);
      final_report();
   end
   initial begin
      repeat (90000) @(posedge clk);
      err_count++;
      $display("mismatch at %0t: watchdog expired", $time);
      final_report();
   end
endmodule : tb_top
